/* File: rucs_pkg.sv */
// Shared constants, types and field layouts of the update configuration sequencer.
package rucs_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WDT = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_MASK = 4'h4;
  localparam logic [3:0] REG_KICK = 4'h5;

  // Control register field positions.
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_WDEN_BIT = 3;
  localparam int CTRL_GO_BIT = 4;
  localparam int CTRL_RELOAD_BIT = 5;

  // Status register field positions.
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_PAGE_LSB = 2;
  localparam int STAT_APP_BIT = 5;
  localparam int STAT_LOCAL_BIT = 6;
  localparam int STAT_BADSCH_BIT = 7;

  // Interrupt status bit positions.
  localparam int IRQ_N = 3;
  localparam int IRQ_LOAD_ERR = 0;
  localparam int IRQ_WDT = 1;
  localparam int IRQ_APP_UP = 2;

  // Page addresses and reset values.
  localparam logic [2:0] FACTORY_PAGE = 3'h0;
  localparam logic [2:0] CTRL_PAGE_RST = 3'h1;
  localparam logic [15:0] WDT_TIMEOUT_RST = 16'h03e8;

  // Watchdog tick: one microsecond at the system clock rate.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WDT_TICK_NS = 1000;
  localparam int WDT_TICK_CYC = (WDT_TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Reconfiguration cause codes.
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_LOAD_ERR = 2'h1,
    CAUSE_WDT = 2'h2,
    CAUSE_USER = 2'h3
  } rucs_cause_t;

  // Loading schemes.
  typedef enum logic [1:0] {
    SCH_SERIAL = 2'h0,
    SCH_PSYNC = 2'h1,
    SCH_PASYNC = 2'h2
  } rucs_scheme_t;

  // Load command toward the configuration source.
  typedef struct packed {
    logic req;
    logic [2:0] page;
    rucs_scheme_t scheme;
  } rucs_load_t;

  // Answer from the configuration source.
  typedef struct packed {
    logic done;
    logic err;
  } rucs_ans_t;

endpackage : rucs_pkg

/* File: rucs_wdog.sv */
// User watchdog with microsecond prescaler and restart input.
`timescale 1ns/1ps
`default_nettype none
module rucs_wdog
  import rucs_pkg::*;
#(
  parameter int TICK_CYC = WDT_TICK_CYC
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Control.
  input wire logic i_en,
  input wire logic i_kick,
  input wire logic [15:0] i_timeout,
  // Expiry pulse.
  output logic o_expire
);

  logic [15:0] pre_ff; // Prescaler toward one tick.
  logic [15:0] nxt_pre;
  logic [15:0] cnt_ff; // Elapsed ticks since the last restart.
  logic [15:0] nxt_cnt;
  logic exp_ff; // Registered expiry pulse.
  logic nxt_exp;
  logic tick; // One-cycle enable from the prescaler.
  logic [15:0] limit; // Timeout with zero treated as one tick.

  assign tick = (pre_ff == 16'(TICK_CYC - 1));
  assign limit = (i_timeout == 16'h0000) ? 16'h0001 : i_timeout;
  assign o_expire = exp_ff;

  // Next values; disable or restart clears both counters so a fresh timeout starts.
  always_comb
  begin
    nxt_pre = tick ? 16'h0000 : pre_ff + 16'h0001;
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (!i_en || i_kick)
    begin
      nxt_pre = 16'h0000;
      nxt_cnt = 16'h0000;
    end
    else if (tick)
    begin
      // Expire once, then start counting again in case the reload is slow.
      if (cnt_ff + 16'h0001 >= limit)
      begin
        nxt_cnt = 16'h0000;
        nxt_exp = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  // Registers only.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      exp_ff <= 1'b0;
    end
    else
    begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

endmodule : rucs_wdog
`default_nettype wire

/* File: rucs_irq.sv */
// Sticky event status with write-one-to-clear, mask and one level interrupt.
`timescale 1ns/1ps
`default_nettype none
module rucs_irq
  import rucs_pkg::*;
#(
  parameter int N = IRQ_N
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Events and software access.
  input wire logic [N-1:0] i_set,
  input wire logic i_stat_wr,
  input wire logic i_mask_wr,
  input wire logic [N-1:0] i_wdata,
  // State and interrupt.
  output logic [N-1:0] o_stat,
  output logic [N-1:0] o_mask,
  output logic o_irq
);

  logic [N-1:0] stat_ff; // Sticky event bits.
  logic [N-1:0] nxt_stat;
  logic [N-1:0] mask_ff; // One enables the bit onto the interrupt.
  logic [N-1:0] nxt_mask;

  // A new event in the clearing cycle survives, so set wins over clear.
  always_comb
  begin
    nxt_stat = stat_ff;
    if (i_stat_wr)
    begin
      nxt_stat = stat_ff & ~i_wdata;
    end
    nxt_stat = nxt_stat | i_set;
    nxt_mask = i_mask_wr ? i_wdata : mask_ff;
  end

  // Registers only.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stat_ff <= '0;
      mask_ff <= '0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  assign o_stat = stat_ff;
  assign o_mask = mask_ff;
  assign o_irq = |(stat_ff & mask_ff);

endmodule : rucs_irq
`default_nettype wire

/* File: rucs_top.sv */
// Update configuration sequencer: factory and application image loading with watchdog.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Remote power-up loads factory page zero first.
// RULE_02: Page zero is never an update target.
// RULE_03: Failed application load records cause, reloads factory.
// RULE_04: Factory writes page, device loads that page.
// RULE_05: Factory chooses watchdog enable and timeout.
// RULE_06: Application keeps restarting the watchdog.
// RULE_07: Watchdog expiry records cause, reloads factory.
// RULE_08: Watchdog always off while factory runs.
// RULE_09: Good application load enters user mode.
// RULE_10: Factory reads cause, then writes next page.
// RULE_11: Application requests factory reload after update.
// RULE_12: Seven application pages, one to seven.
// RULE_13: Asynchronous parallel refused from paged memory.
// RULE_14: Local mode loads application page directly.
// RULE_15: Watchdog and load error causes differ.
module rucs_top
  import rucs_pkg::*;
#(
  parameter logic [2:0] LOCAL_PAGE = 3'h1,
  parameter int TICK_CYC = WDT_TICK_CYC
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Straps, sampled once after reset release.
  input wire logic i_local_mode,
  input wire rucs_scheme_t i_scheme,
  input wire logic i_src_paged,
  // Register port.
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Configuration source.
  output rucs_load_t o_load,
  input wire rucs_ans_t i_ans,
  // Device state.
  output logic o_user_mode,
  output logic o_app_run,
  output logic o_irq
);

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HALT = 4'b1000
  } rucs_state_t;

  rucs_state_t state_ff; // Sequencer state.
  rucs_state_t nxt_state;
  logic [2:0] page_ff; // Page being loaded or running.
  logic [2:0] nxt_page;
  logic app_ff; // Loaded image is an application.
  logic nxt_app;
  logic local_ff; // Local update mode strap.
  logic nxt_local;
  logic badsch_ff; // Scheme strap unusable with the source.
  logic nxt_badsch;
  rucs_scheme_t scheme_ff; // Scheme strap.
  rucs_scheme_t nxt_scheme;
  rucs_cause_t cause_ff; // Reason for the last reconfiguration.
  rucs_cause_t nxt_cause;
  logic armed_ff; // Watchdog enable captured for the running application.
  logic nxt_armed;
  logic [2:0] cpage_ff; // Next application page written by software.
  logic [2:0] nxt_cpage;
  logic wden_ff; // Watchdog enable written by software.
  logic nxt_wden;
  logic [15:0] tmo_ff; // Watchdog timeout in microseconds.
  logic [15:0] nxt_tmo;
  logic [DATA_W-1:0] rdata_ff; // Read data, valid the cycle after the strobe.
  logic [DATA_W-1:0] nxt_rdata;

  logic [IRQ_N-1:0] ev_set; // Event pulses toward the status bits.
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_mask;
  logic wd_en; // Watchdog running.
  logic wd_expire; // Watchdog timeout pulse.
  logic kick; // Watchdog restart write.
  logic ctrl_wr; // Control register write.
  logic go_ok; // Accepted request to load an application page.
  logic reload_req; // Request from the application to return to factory.

  // Checks a page request: only one to seven are application pages.
  function automatic logic page_valid(input logic [2:0] p);
    page_valid = (p != FACTORY_PAGE);
  endfunction : page_valid

  assign ctrl_wr = i_wr && (i_addr == REG_CTRL);
  assign kick = i_wr && (i_addr == REG_KICK);
  // Go is honoured only from the running factory image with an application page.
  assign go_ok = ctrl_wr && i_wdata[CTRL_GO_BIT] && (state_ff == ST_RUN) && !app_ff
    && page_valid(i_wdata[CTRL_PAGE_LSB +: 3]); // RULE_04 RULE_12 RULE_02
  assign reload_req = ctrl_wr && i_wdata[CTRL_RELOAD_BIT] && (state_ff == ST_RUN)
    && app_ff && !local_ff; // RULE_11
  // The factory image never runs under the watchdog, nor does a local image.
  assign wd_en = (state_ff == ST_RUN) && app_ff && armed_ff && !local_ff; // RULE_08

  // Control and timeout registers that the factory image programs.
  always_comb
  begin
    nxt_cpage = cpage_ff;
    nxt_wden = wden_ff;
    nxt_tmo = tmo_ff;
    if (ctrl_wr)
    begin
      // A page of zero is refused so the factory page cannot be chosen as an update.
      if (page_valid(i_wdata[CTRL_PAGE_LSB +: 3]))
      begin
        nxt_cpage = i_wdata[CTRL_PAGE_LSB +: 3]; // RULE_12
      end
      nxt_wden = i_wdata[CTRL_WDEN_BIT]; // RULE_05
    end
    if (i_wr && (i_addr == REG_WDT))
    begin
      nxt_tmo = i_wdata[15:0]; // RULE_05
    end
  end

  // Sequencer next state.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_page = page_ff;
    nxt_app = app_ff;
    nxt_local = local_ff;
    nxt_badsch = badsch_ff;
    nxt_scheme = scheme_ff;
    nxt_cause = cause_ff;
    nxt_armed = armed_ff;
    ev_set = '0;
    case (state_ff)
      ST_STRAP:
      begin
        // Straps are caught here, after release, not under the reset.
        nxt_local = i_local_mode;
        nxt_scheme = i_scheme;
        nxt_badsch = (i_scheme == SCH_PASYNC) && i_src_paged; // RULE_13
        if (!(i_scheme inside {SCH_SERIAL, SCH_PSYNC, SCH_PASYNC}) ||
            ((i_scheme == SCH_PASYNC) && i_src_paged))
        begin
          nxt_badsch = 1'b1;
          nxt_state = ST_HALT; // RULE_13
        end
        else if (i_local_mode)
        begin
          nxt_page = LOCAL_PAGE; // RULE_14
          nxt_app = 1'b1;
          nxt_state = ST_LOAD;
        end
        else
        begin
          nxt_page = FACTORY_PAGE; // RULE_01
          nxt_app = 1'b0;
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        // An error beats a done that arrives in the same cycle.
        if (i_ans.err)
        begin
          ev_set[IRQ_LOAD_ERR] = 1'b1;
          if (app_ff && !local_ff)
          begin
            nxt_cause = CAUSE_LOAD_ERR; // RULE_03 RULE_15
            nxt_page = FACTORY_PAGE; // RULE_03
            nxt_app = 1'b0;
          end
          // A failing factory or local image is simply retried; nothing else can run.
        end
        else if (i_ans.done)
        begin
          nxt_state = ST_RUN; // RULE_09
          ev_set[IRQ_APP_UP] = app_ff;
        end
      end
      ST_RUN:
      begin
        if (wd_expire && wd_en)
        begin
          ev_set[IRQ_WDT] = 1'b1;
          nxt_cause = CAUSE_WDT; // RULE_07 RULE_15
          nxt_page = FACTORY_PAGE; // RULE_07
          nxt_app = 1'b0;
          nxt_state = ST_LOAD;
        end
        else if (reload_req)
        begin
          nxt_cause = CAUSE_USER; // RULE_11
          nxt_page = FACTORY_PAGE;
          nxt_app = 1'b0;
          nxt_state = ST_LOAD;
        end
        else if (go_ok)
        begin
          // The enable is frozen at launch so the application cannot switch it off.
          nxt_page = i_wdata[CTRL_PAGE_LSB +: 3]; // RULE_04
          nxt_armed = i_wdata[CTRL_WDEN_BIT]; // RULE_05
          nxt_app = 1'b1;
          nxt_state = ST_LOAD;
        end
      end
      ST_HALT:
      begin
        // No legal scheme: stay idle until the next reset.
        nxt_state = ST_HALT;
      end
      default:
      begin
        nxt_state = ST_STRAP;
      end
    endcase
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    nxt_rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        REG_CTRL: nxt_rdata = {26'h0, 1'b0, 1'b0, wden_ff, cpage_ff};
        REG_WDT: nxt_rdata = {16'h0000, tmo_ff};
        REG_STATUS: nxt_rdata = {24'h0, badsch_ff, local_ff, app_ff, page_ff, cause_ff}; // RULE_10
        REG_IRQ_STAT: nxt_rdata = {29'h0, irq_stat};
        REG_IRQ_MASK: nxt_rdata = {29'h0, irq_mask};
        default: nxt_rdata = '0;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_STRAP;
      page_ff <= FACTORY_PAGE;
      app_ff <= 1'b0;
      local_ff <= 1'b0;
      badsch_ff <= 1'b0;
      scheme_ff <= SCH_SERIAL;
      cause_ff <= CAUSE_NONE;
      armed_ff <= 1'b0;
      cpage_ff <= CTRL_PAGE_RST;
      wden_ff <= 1'b0;
      tmo_ff <= WDT_TIMEOUT_RST;
      rdata_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      page_ff <= nxt_page;
      app_ff <= nxt_app;
      local_ff <= nxt_local;
      badsch_ff <= nxt_badsch;
      scheme_ff <= nxt_scheme;
      cause_ff <= nxt_cause;
      armed_ff <= nxt_armed;
      cpage_ff <= nxt_cpage;
      wden_ff <= nxt_wden;
      tmo_ff <= nxt_tmo;
      rdata_ff <= nxt_rdata;
    end
  end

  // Watchdog, restarted by the application through the kick register.
  rucs_wdog #(
    .TICK_CYC(TICK_CYC)
  ) u_wdog (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_en(wd_en),
    .i_kick(kick), // RULE_06
    .i_timeout(tmo_ff),
    .o_expire(wd_expire)
  );

  // Event status, mask and interrupt.
  rucs_irq #(
    .N(IRQ_N)
  ) u_irq (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(ev_set),
    .i_stat_wr(i_wr && (i_addr == REG_IRQ_STAT)),
    .i_mask_wr(i_wr && (i_addr == REG_IRQ_MASK)),
    .i_wdata(i_wdata[IRQ_N-1:0]),
    .o_stat(irq_stat),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  assign o_rdata = rdata_ff;
  // One driver for the whole load command keeps the struct a single net for strict tools.
  assign o_load = '{req: (state_ff == ST_LOAD), page: page_ff, scheme: scheme_ff};
  assign o_user_mode = (state_ff == ST_RUN);
  assign o_app_run = (state_ff == ST_RUN) && app_ff;

  // Failure of a remote application load in the load state.
  sequence s_app_fail;
    (state_ff == ST_LOAD) && app_ff && !local_ff && i_ans.err;
  endsequence

  a_factory_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_01
    (state_ff == ST_STRAP) && !i_local_mode && (i_scheme inside {SCH_SERIAL, SCH_PSYNC})
    |=> o_load.req && (o_load.page == FACTORY_PAGE) && !o_app_run)
    else $error("first remote load is not page zero");
  a_load_err: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_03
    s_app_fail |=> (cause_ff == CAUSE_LOAD_ERR) && (o_load.page == FACTORY_PAGE) && o_load.req)
    else $error("load error did not return to factory");
  a_go_page: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_04
    go_ok && !wd_expire && !reload_req
    |=> o_load.req && (o_load.page == $past(i_wdata[2:0])) && (o_load.page != 3'h0))
    else $error("factory page request not loaded");
  a_wdt_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_07
    wd_expire && wd_en
    |=> (cause_ff == CAUSE_WDT) && (o_load.page == FACTORY_PAGE) && o_load.req
    && irq_stat[IRQ_WDT])
    else $error("watchdog expiry not recorded");
  a_wdt_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_08
    o_user_mode && !o_app_run |-> !wd_en ##1 !wd_expire)
    else $error("watchdog running under factory image");
  a_user_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_09
    (state_ff == ST_LOAD) && i_ans.done && !i_ans.err |=> o_user_mode && !o_load.req)
    else $error("good load did not enter user mode");
  a_pasync_halt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_13
    (state_ff == ST_STRAP) && (i_scheme == SCH_PASYNC) && i_src_paged
    |=> (!o_load.req && !o_user_mode)[*4])
    else $error("asynchronous load from paged memory not refused");
  a_local_direct: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_14
    (state_ff == ST_STRAP) && i_local_mode && (i_scheme inside {SCH_SERIAL, SCH_PSYNC})
    |=> o_load.req && (o_load.page == LOCAL_PAGE) && app_ff)
    else $error("local mode did not load application directly");
  a_cause_split: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_15
    s_app_fail |=> (cause_ff != CAUSE_WDT) && (cause_ff != CAUSE_NONE))
    else $error("load error cause not distinct");
  a_read_late: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_10
    i_rd && (i_addr == REG_STATUS) |=> (o_rdata[1:0] == $past(cause_ff)))
    else $error("status read shows wrong cause");

endmodule : rucs_top
`default_nettype wire

/* File: rucs_mem_model.sv */
// Behavioural paged configuration memory that answers the sequencer's load requests.
`timescale 1ns/1ps
`default_nettype none
module rucs_mem_model
  import rucs_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Load link.
  input wire rucs_load_t i_load,
  output rucs_ans_t o_ans,
  // Test controls: latency, corrupt page, paged memory or host.
  input wire logic [3:0] i_delay,
  input wire logic i_err_en,
  input wire logic [2:0] i_err_page,
  input wire logic i_paged
);
  logic [3:0] wait_ff; // Cycles left before the answer.
  logic [3:0] nxt_wait; // Next latency count.
  rucs_ans_t nxt_ans; // Next answer pulse.

  // The model has no write path, so the factory page can never be spoiled.
  // A corrupt image is only ever placed on an application page.
  always_comb
  begin
    nxt_ans = '0;
    nxt_wait = wait_ff;
    if (!i_load.req)
    begin
      // Idle: rearm the latency so every load sees the full delay.
      nxt_wait = i_delay;
    end
    else if (i_paged && (i_load.scheme == SCH_PASYNC))
    begin
      // A paged memory offers only serial and synchronous loading.
      nxt_wait = i_delay;
    end
    else if (wait_ff == 4'h0)
    begin
      // Answer once, then rearm; the latency stops a second pulse.
      nxt_ans.err = i_err_en && (i_load.page == i_err_page) && (i_load.page != FACTORY_PAGE);
      nxt_ans.done = !nxt_ans.err;
      nxt_wait = i_delay;
    end
    else
    begin
      nxt_wait = wait_ff - 4'h1;
    end
  end

  // Register the answer so it is a clean one-cycle pulse.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_ff <= 4'h3;
      o_ans <= '0;
    end
    else
    begin
      wait_ff <= nxt_wait;
      o_ans <= nxt_ans;
    end
  end
endmodule : rucs_mem_model
`default_nettype wire

/* File: rucs_top_tb.sv */
// Self-checking testbench of the update configuration sequencer.
`timescale 1ns/1ps
`default_nettype none
module rucs_top_tb
  import rucs_pkg::*;
;
  localparam logic [2:0] LP = 3'h1; // Page of the local image.
  logic clk, rst_n, local_mode, src_paged, wr, rd, user_mode, app_run, irq;
  rucs_scheme_t scheme;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  rucs_load_t load;
  rucs_ans_t ans;
  logic [3:0] m_delay;
  logic m_err_en;
  logic [2:0] m_err_page;
  int n_fail, n_checks;

  // A short tick keeps watchdog runs brief.
  rucs_top #(.LOCAL_PAGE(LP), .TICK_CYC(4)) dut_u (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_local_mode(local_mode), .i_scheme(scheme), .i_src_paged(src_paged), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_load(load), .i_ans(ans),
    .o_user_mode(user_mode), .o_app_run(app_run), .o_irq(irq));
  rucs_mem_model mem_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_load(load), .o_ans(ans),
    .i_delay(m_delay), .i_err_en(m_err_en), .i_err_page(m_err_page), .i_paged(src_paged));

  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic do_reset(input logic l, input rucs_scheme_t s, input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    local_mode <= l;
    scheme <= s;
    src_paged <= p;
    cyc(5);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wait_req(input logic [2:0] p);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (load.req !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(load.req, 1, "load request");
    chk(load.page, p, "load page");
  endtask : wait_req

  task automatic wait_up();
    int k;
    k = 0;
    while (user_mode !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(user_mode, 1, "user mode");
  endtask : wait_up

  task automatic go(input logic [2:0] p, input logic wden);
    logic [31:0] d;
    d = '0;
    d[CTRL_PAGE_LSB+:3] = p;
    d[CTRL_WDEN_BIT] = wden;
    d[CTRL_GO_BIT] = 1'b1;
    reg_wr(REG_CTRL, d);
  endtask : go

  task automatic t_powerup();
    wait_req(FACTORY_PAGE);
    wait_up();
    chk(app_run, 0, "factory is not an application");
    reg_rd(REG_STATUS, rv);
    chk(rv, 32'h0, "status after power-up");
    reg_rd(REG_WDT, rv);
    chk(rv, 32'h3e8, "timeout reset value");
    reg_rd(REG_IRQ_MASK, rv);
    chk(rv, 32'h0, "mask reset value");
    reg_wr(4'hf, 32'hffffffff);
    reg_rd(4'hf, rv);
    chk(rv, 32'h0, "unmapped offset");
  endtask : t_powerup

  // Every application page, each left again by a user reload.
  task automatic t_pages();
    logic [31:0] d;
    reg_wr(REG_IRQ_STAT, 32'h7);
    // A request for the factory page must leave the factory image running.
    go(3'h0, 1'b0);
    cyc(3);
    chk({user_mode, app_run, load.req}, 32'h4, "page zero refused");
    reg_rd(REG_CTRL, rv);
    chk(rv, 32'(CTRL_PAGE_RST), "page zero not stored");
    for (int p = 1; p <= 7; p++)
    begin
      m_delay <= p[0] ? 4'h9 : 4'h2;
      go(3'(p), 1'b0);
      wait_req(3'(p));
      wait_up();
      chk(app_run, 1, "application running");
      reg_rd(REG_STATUS, rv);
      chk(rv & 32'h3c, 32'h20 | (32'(p) << STAT_PAGE_LSB), "application status");
      reg_rd(REG_IRQ_STAT, rv);
      chk(rv[IRQ_APP_UP], 1, "application up event");
      d = '0;
      d[CTRL_RELOAD_BIT] = 1'b1;
      reg_wr(REG_CTRL, d);
      wait_req(FACTORY_PAGE);
      wait_up();
      reg_rd(REG_STATUS, rv);
      chk(rv & 32'h3f, 32'(CAUSE_USER), "user reload cause");
    end
  endtask : t_pages

  task automatic t_load_err();
    int k;
    k = 0;
    reg_wr(REG_IRQ_STAT, 32'h7);
    reg_wr(REG_IRQ_MASK, 32'h1);
    m_err_page <= 3'h5;
    m_err_en <= 1'b1;
    go(3'h5, 1'b1);
    wait_req(3'h5);
    while (load.page !== FACTORY_PAGE && k < 100)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(load.req, 1, "factory reload after error");
    wait_up();
    reg_rd(REG_STATUS, rv);
    chk(rv, 32'(CAUSE_LOAD_ERR), "load error status");
    reg_rd(REG_IRQ_STAT, rv);
    chk(rv, 32'h1, "load error event");
    chk(irq, 1, "unmasked interrupt");
    reg_wr(REG_IRQ_STAT, 32'h1);
    #1 chk(irq, 0, "interrupt cleared");
    m_err_en <= 1'b0;
  endtask : t_load_err

  task automatic t_wdog();
    reg_wr(REG_IRQ_STAT, 32'h7);
    reg_wr(REG_WDT, 32'h3);
    go(3'h2, 1'b1);
    wait_req(3'h2);
    wait_up();
    // Restarts spaced well inside the twelve-cycle timeout.
    repeat (6)
    begin
      reg_wr(REG_KICK, 32'h0);
      cyc(3);
    end
    chk(app_run, 1, "kept alive by restarts");
    wait_req(FACTORY_PAGE);
    wait_up();
    reg_rd(REG_STATUS, rv);
    chk(rv, 32'(CAUSE_WDT), "watchdog status");
    reg_rd(REG_IRQ_STAT, rv);
    chk(rv[IRQ_WDT], 1, "watchdog event");
    cyc(60);
    chk({user_mode, load.req}, 32'h2, "factory ignores watchdog");
  endtask : t_wdog

  task automatic t_straps();
    for (int s = 0; s < 2; s++)
    begin
      do_reset(1'b0, rucs_scheme_t'(s), 1'b1);
      wait_req(FACTORY_PAGE);
      chk(load.scheme, s, "scheme on link");
    end
    do_reset(1'b0, SCH_PASYNC, 1'b1);
    cyc(30);
    chk(load.req, 0, "asynchronous from paged memory");
    reg_rd(REG_STATUS, rv);
    chk(rv[STAT_BADSCH_BIT], 1, "bad scheme flag");
    do_reset(1'b0, SCH_PASYNC, 1'b0);
    wait_req(FACTORY_PAGE);
    do_reset(1'b1, SCH_SERIAL, 1'b1);
    wait_req(LP);
    wait_up();
    reg_rd(REG_STATUS, rv);
    chk(rv & 32'h5c, 32'h40 | (32'(LP) << STAT_PAGE_LSB), "local status");
  endtask : t_straps

  // Main sequence.
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    local_mode = 1'b0;
    scheme = SCH_SERIAL;
    src_paged = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    m_delay = 4'h2;
    m_err_en = 1'b0;
    m_err_page = 3'h0;
    do_reset(1'b0, SCH_SERIAL, 1'b1);
    t_powerup();
    t_pages();
    t_load_err();
    t_wdog();
    t_straps();
    wrap_up();
  end

  // Watchdog on the whole run; the tests need well under a tenth of this.
  initial
  begin
    #200us;
    n_fail++;
    $display("mismatch at %0t: run timed out", $time);
    wrap_up();
  end
endmodule : rucs_top_tb
`default_nettype wire
